//--- hdl/fcvs_elem.sv
// One frequency element: combined gradient, interval-change and vector surge modes.
`timescale 1ns/10ps
module fcvs_elem
  import fcvs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  fcvs_elem_if.elem e
);
  logic [PHASES-1:0] beyond;
  logic [PHASES-1:0] g_ok;
  logic [PHASES-1:0] changed;
  logic [PHASES-1:0] sv_flag_q;
  logic [PHASES-1:0][FW-1:0] fref_q;
  logic [FW-1:0] tmr_q, tmr_d;
  logic alarm_q, alarm_d, trip_q, trip_d, act_q, act_d, lock_q, lock_d, beyond_prev_q;

  wire under = (e.mode == FCVS_UF_GRAD) || (e.mode == FCVS_UF_CHG);
  wire grad_mode = (e.mode == FCVS_UF_GRAD) || (e.mode == FCVS_OF_GRAD);
  wire chg_mode = (e.mode == FCVS_UF_CHG) || (e.mode == FCVS_OF_CHG);
  wire surge_mode = e.mode == FCVS_SURGE;
  for (genvar p = 0; p < PHASES; p++) begin : g_ph
    assign beyond[p] = under ? (e.freq[p] < e.pickup) : (e.freq[p] > e.pickup);
    assign g_ok[p] = grad_exceeds(e.grad[p], e.grad_thr, e.dir);
    assign changed[p] = freq_change_met(fref_q[p], e.freq[p], e.chg_limit, under);
  end
  wire beyond_any = |beyond;
  wire comb_pick = grad_mode && (|(beyond & g_ok)) && !e.blk;
  wire chg_start = chg_mode && beyond_any && !beyond_prev_q && !e.blk && !lock_q;
  wire chg_keep = chg_mode && beyond_any && !e.blk && (act_q || chg_start);
  wire expired = tmr_q >= e.interval;
  wire chg_hit = act_q && !expired && (|(beyond & changed));
  wire chg_lapse = act_q && chg_keep && expired && !trip_q;
  wire [1:0] hit_cnt = 2'(sv_flag_q[0]) + 2'(sv_flag_q[1]) + 2'(sv_flag_q[2]);
  wire [1:0] need_cnt = (e.phreq == FCVS_PH_ALL) ? 2'h3 : (e.phreq == FCVS_PH_TWO) ? 2'h2 : 2'h1;
  wire surge_pick = surge_mode && (hit_cnt >= need_cnt) && !e.blk && !e.ploss && !e.uv;
  wire [FW-1:0] tmr_inc = (e.tick && (tmr_q != {FW{1'b1}})) ? FW'(tmr_q + 1'b1) : tmr_q;

  always_comb begin
    alarm_d = 1'b0;
    trip_d = 1'b0;
    act_d = 1'b0;
    tmr_d = '0;
    lock_d = lock_q && beyond_any && chg_mode;
    case (e.mode)
      FCVS_UF_GRAD, FCVS_OF_GRAD: begin
        alarm_d = comb_pick;
        trip_d = comb_pick && (tmr_q >= e.delay);
        tmr_d = comb_pick ? tmr_inc : '0;
      end
      FCVS_UF_CHG, FCVS_OF_CHG: begin
        alarm_d = chg_keep;
        act_d = chg_keep && !chg_lapse;
        trip_d = act_d && (trip_q || chg_hit);
        tmr_d = (act_q && chg_keep) ? tmr_inc : '0;
        if (chg_lapse) begin
          lock_d = 1'b1;
        end
      end
      FCVS_SURGE: begin
        alarm_d = surge_pick;
        trip_d = surge_pick;
      end
      default: begin
        alarm_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    for (int p = 0; p < PHASES; p++) begin
      if (!aresetn || e.uv) begin
        sv_flag_q[p] <= 1'b0;
      end else if (e.sv_valid[p]) begin
        sv_flag_q[p] <= angle_exceeds(e.dev[p], e.refc[p], e.surge_thr);
      end
      if (!aresetn) begin
        fref_q[p] <= '0;
      end else if (chg_start) begin
        fref_q[p] <= e.freq[p];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {alarm_q, trip_q, act_q, lock_q, beyond_prev_q} <= '0;
      tmr_q <= '0;
    end else begin
      {alarm_q, trip_q, act_q, lock_q, beyond_prev_q} <= {alarm_d, trip_d, act_d, lock_d, beyond_any};
      tmr_q <= tmr_d;
    end
  end
  assign e.alarm = alarm_q;
  assign e.trip = trip_q;

  property p_grad_alarm;
    @(posedge aclk) disable iff (!aresetn) comb_pick |=> alarm_q;
  endproperty
  a_grad_alarm: assert property (p_grad_alarm) else $error("gradient pickup without alarm");
  property p_grad_trip;
    @(posedge aclk) disable iff (!aresetn) (trip_q && $past(grad_mode)) |-> $past(comb_pick && (tmr_q >= e.delay));
  endproperty
  a_grad_trip: assert property (p_grad_trip) else $error("gradient trip without condition");
  property p_block_drop;
    @(posedge aclk) disable iff (!aresetn) (e.blk && !surge_mode) |=> !alarm_q && !trip_q;
  endproperty
  a_block_drop: assert property (p_block_drop) else $error("alarm stays under block");
  property p_chg_window;
    @(posedge aclk) disable iff (!aresetn) ($rose(trip_q) && $past(chg_mode)) |-> $past(act_q && !expired);
  endproperty
  a_chg_window: assert property (p_chg_window) else $error("change trip outside interval");
  property p_lock_hold;
    @(posedge aclk) disable iff (!aresetn) (lock_q && beyond_any && chg_mode) |=> !alarm_q;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked element rearmed");
  property p_surge_now;
    @(posedge aclk) disable iff (!aresetn) surge_pick |=> alarm_q && trip_q;
  endproperty
  a_surge_now: assert property (p_surge_now) else $error("surge trip not immediate");
  property p_ploss;
    @(posedge aclk) disable iff (!aresetn) (surge_mode && e.ploss) |=> !trip_q;
  endproperty
  a_ploss: assert property (p_ploss) else $error("surge trip with phase lost");
  c_chg_trip: cover property (@(posedge aclk) disable iff (!aresetn) chg_mode && $rose(trip_q));
  c_lock: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lock_q));
  c_surge: cover property (@(posedge aclk) disable iff (!aresetn) surge_mode && $rose(trip_q));
endmodule

//--- hdl/fcvs_top.sv
// Top of the frequency protection block: AXI4-Lite registers, cycle measurement and six elements.
// Operation
// - Under mode: frequency low and gradient high.
// - Over mode: frequency high and gradient high.
// - Gradient direction: positive, negative or absolute.
// - Both conditions, unblocked: alarm, start delay.
// - Trip at delay end if still met.
// - Change counts down for under, up for over.
// - Crossing pickup unblocked: alarm, start interval.
// - Change reached within interval: trip at once.
// - Interval lapsed: no trip, lock until recross.
// - Restart cycle measurement at each zero crossing.
// - Cycle deviation from reference gives surge angle.
// - Angle above threshold trips without delay.
// - Phase count: three, two or one phases.
// - Lost phase inhibits surge trip.
// - Low voltage inhibits surge measurement, instantly.
// - Mains failure tripped within 60 ms.
// - Gradient refreshed at every zero crossing.
// - Gradient window settable from 2 to 10.
// - Six independent, individually configured elements.
`timescale 1ns/10ps
module fcvs_top
  import fcvs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DFLT,
  parameter int MAINS_FAIL_CYC = MAINS_FAIL_CYC_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DW-1:0] s_axi_wdata,
  input wire logic [DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PHASES-1:0][FW-1:0] freq_ph,
  input wire logic [PHASES-1:0][FW-1:0] grad_ph,
  input wire logic [PHASES-1:0] zc_ph,
  input wire logic uv_lock,
  input wire logic phase_loss,
  input wire logic [NELEM-1:0] elem_block,
  output logic [WIN_W-1:0] grad_window,
  output logic [NELEM-1:0] alarm,
  output logic [NELEM-1:0] trip
);
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [CW-1:0] FAIL_LAST = CW'(MAINS_FAIL_CYC - 1);

  function automatic logic is_elem_reg(input logic [AW-1:0] a);
    is_elem_reg = (a >= ELEM_BASE) && (a[REG_IDX_LSB +: 3] < 3'(EREGS)) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [2:0] elem_of(input logic [AW-1:0] a);
    elem_of = 3'(a[AW-1:ELEM_IDX_LSB] - ELEM_BASE_IDX);
  endfunction

  logic [FW-1:0] ereg_q [NELEM][EREGS];
  logic [WIN_W-1:0] grad_win_q;
  logic [AW-1:0] waddr_q;
  logic [DW-1:0] wdata_q;
  logic [DW/8-1:0] wstrb_q;
  logic aw_v_q, w_v_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DW-1:0] rdata_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [PHASES-1:0][FW-1:0] grad_q;
  logic [PHASES-1:0][CW-1:0] cyc_q, ref_q, dev_q, refo_q;
  logic [PHASES-1:0] refv_q, sv_valid_q, seen_q;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_do = aw_v_q && w_v_q && !bvalid_q;
  wire wr_elem = is_elem_reg(waddr_q);
  wire wr_win = waddr_q == REG_GRAD_WIN;
  wire wr_hit = wr_elem || wr_win || (waddr_q == REG_STATUS);
  wire [2:0] wr_ei = elem_of(waddr_q);
  wire [2:0] wr_ri = waddr_q[REG_IDX_LSB +: 3];
  wire [DW-1:0] wr_merged = apply_strb(32'(ereg_q[wr_ei][wr_ri]), wdata_q, wstrb_q);
  wire [DW-1:0] win_merged = apply_strb(32'(grad_win_q), wdata_q, wstrb_q);
  wire [WIN_W-1:0] win_req = (win_merged[DW-1:WIN_W] != '0) ? GRAD_WIN_MAX : win_merged[WIN_W-1:0];
  wire [WIN_W-1:0] win_clamp = (win_req < GRAD_WIN_MIN) ? GRAD_WIN_MIN :
                               (win_req > GRAD_WIN_MAX) ? GRAD_WIN_MAX : win_req;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_elem = is_elem_reg(s_axi_araddr);
  wire [2:0] rd_ei = elem_of(s_axi_araddr);
  wire [2:0] rd_ri = s_axi_araddr[REG_IDX_LSB +: 3];
  wire [DW-1:0] status = (32'(trip) << STAT_TRIP_LSB) | 32'(alarm);
  wire rd_hit = rd_elem || (s_axi_araddr == REG_GRAD_WIN) || (s_axi_araddr == REG_STATUS);
  wire [DW-1:0] rd_val = (s_axi_araddr == REG_GRAD_WIN) ? 32'(grad_win_q) :
                         (s_axi_araddr == REG_STATUS) ? status :
                         rd_elem ? 32'(ereg_q[rd_ei][rd_ri]) : 32'h0000_0000;

  assign s_axi_awready = !aw_v_q;
  assign s_axi_wready = !w_v_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign grad_window = grad_win_q;

  // Address and data are held separately so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_v_q, w_v_q, bvalid_q} <= '0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_v_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_v_q <= 1'b0;
      end
      if (w_hs) begin
        w_v_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_v_q <= 1'b0;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NELEM; i++) begin
        for (int j = 0; j < EREGS; j++) begin
          ereg_q[i][j] <= EREG_RST;
        end
      end
      grad_win_q <= GRAD_WIN_MIN;
    end else if (wr_do && wr_elem) begin
      ereg_q[wr_ei][wr_ri] <= wr_merged[FW-1:0];
    end else if (wr_do && wr_win) begin
      grad_win_q <= win_clamp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Millisecond tick shared by all element timers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == TICK_LAST;
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : TICK_W'(tick_cnt_q + 1'b1);
    end
  end

  // A missing zero crossing closes the cycle at the mains failure limit, so a dead
  // phase is still judged in time; undervoltage discards the reference entirely.
  for (genvar p = 0; p < PHASES; p++) begin : g_meas
    wire cyc_end = zc_ph[p] || (cyc_q[p] >= FAIL_LAST);
    wire [CW-1:0] dur = CW'(cyc_q[p] + 1'b1);
    wire [CW-1:0] dev = (dur >= ref_q[p]) ? CW'(dur - ref_q[p]) : CW'(ref_q[p] - dur);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        grad_q[p] <= '0;
      end else if (zc_ph[p]) begin
        grad_q[p] <= grad_ph[p];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || uv_lock) begin
        {cyc_q[p], ref_q[p], dev_q[p], refo_q[p]} <= '0;
        {refv_q[p], sv_valid_q[p], seen_q[p]} <= '0;
      end else begin
        cyc_q[p] <= cyc_end ? '0 : dur;
        sv_valid_q[p] <= cyc_end && refv_q[p];
        if (cyc_end) begin
          dev_q[p] <= dev;
          refo_q[p] <= ref_q[p];
          seen_q[p] <= 1'b1;
          // The first cycle after reset or lockout is cut short, so it never becomes the reference.
          if (seen_q[p]) begin
            ref_q[p] <= dur;
            refv_q[p] <= 1'b1;
          end
        end
      end
    end
  end

  for (genvar i = 0; i < NELEM; i++) begin : g_elem
    fcvs_elem_if u_eif ();
    assign u_eif.mode = fcvs_mode_t'(ereg_q[i][EREG_CFG][CFG_MODE_LSB +: MODE_W]);
    assign u_eif.dir = fcvs_dir_t'(ereg_q[i][EREG_CFG][CFG_DIR_LSB +: DIR_W]);
    assign u_eif.phreq = fcvs_phreq_t'(ereg_q[i][EREG_CFG][CFG_PHREQ_LSB +: PHREQ_W]);
    assign u_eif.pickup = ereg_q[i][EREG_PICKUP];
    assign u_eif.grad_thr = ereg_q[i][EREG_GRAD_THR];
    assign u_eif.delay = ereg_q[i][EREG_DELAY];
    assign u_eif.chg_limit = ereg_q[i][EREG_CHG_LIMIT];
    assign u_eif.interval = ereg_q[i][EREG_INTERVAL];
    assign u_eif.surge_thr = ereg_q[i][EREG_SURGE_THR];
    assign u_eif.freq = freq_ph;
    assign u_eif.grad = grad_q;
    assign u_eif.dev = dev_q;
    assign u_eif.refc = refo_q;
    assign u_eif.sv_valid = sv_valid_q;
    assign u_eif.blk = elem_block[i];
    assign u_eif.uv = uv_lock;
    assign u_eif.ploss = phase_loss;
    assign u_eif.tick = tick_q;
    assign alarm[i] = u_eif.alarm;
    assign trip[i] = u_eif.trip;
    fcvs_elem u_elem (
      .aclk(aclk),
      .aresetn(aresetn),
      .e(u_eif)
    );
  end

  property p_reset_clear;
    @(posedge aclk) !aresetn |=> (alarm == '0) && (trip == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
  property p_uv_inhibit;
    @(posedge aclk) disable iff (!aresetn) uv_lock |=> (sv_valid_q == '0) && (refv_q == '0);
  endproperty
  a_uv_inhibit: assert property (p_uv_inhibit) else $error("surge measured at low voltage");
  property p_grad_latch;
    @(posedge aclk) disable iff (!aresetn) zc_ph[0] |=> grad_q[0] == $past(grad_ph[0]);
  endproperty
  a_grad_latch: assert property (p_grad_latch) else $error("gradient not refreshed");
  property p_fail_bound;
    @(posedge aclk) disable iff (!aresetn) cyc_q[0] <= FAIL_LAST;
  endproperty
  a_fail_bound: assert property (p_fail_bound) else $error("cycle exceeds failure limit");
  property p_zc_restart;
    @(posedge aclk) disable iff (!aresetn) (zc_ph[1] && !uv_lock) |=> cyc_q[1] == '0;
  endproperty
  a_zc_restart: assert property (p_zc_restart) else $error("cycle not restarted at crossing");
  property p_win_range;
    @(posedge aclk) disable iff (!aresetn) (grad_win_q >= GRAD_WIN_MIN) && (grad_win_q <= GRAD_WIN_MAX);
  endproperty
  a_win_range: assert property (p_win_range) else $error("gradient window out of range");
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_do && wr_elem);
  c_eval: cover property (@(posedge aclk) disable iff (!aresetn) sv_valid_q[0]);
endmodule

//--- inc/fcvs_elem_if.sv
// Settings, measurements and results passed between the top and one protection element.
`timescale 1ns/10ps
interface fcvs_elem_if;
  import fcvs_pkg::*;
  fcvs_mode_t mode;
  fcvs_dir_t dir;
  fcvs_phreq_t phreq;
  logic [FW-1:0] pickup;
  logic [FW-1:0] grad_thr;
  logic [FW-1:0] delay;
  logic [FW-1:0] chg_limit;
  logic [FW-1:0] interval;
  logic [FW-1:0] surge_thr;
  logic [PHASES-1:0][FW-1:0] freq;
  logic [PHASES-1:0][FW-1:0] grad;
  logic [PHASES-1:0][CW-1:0] dev;
  logic [PHASES-1:0][CW-1:0] refc;
  logic [PHASES-1:0] sv_valid;
  logic blk;
  logic uv;
  logic ploss;
  logic tick;
  logic alarm;
  logic trip;
  modport top (output mode, dir, phreq, pickup, grad_thr, delay, chg_limit, interval, surge_thr,
               output freq, grad, dev, refc, sv_valid, blk, uv, ploss, tick, input alarm, trip);
  modport elem (input mode, dir, phreq, pickup, grad_thr, delay, chg_limit, interval, surge_thr,
                input freq, grad, dev, refc, sv_valid, blk, uv, ploss, tick, output alarm, trip);
endinterface

//--- inc/fcvs_pkg.sv
// Shared constants, types and helper functions of the frequency combo and vector surge protection block.
package fcvs_pkg;
  localparam int PHASES = 3;
  localparam int NELEM = 6;
  localparam int FW = 16;
  localparam int CW = 22;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int EREGS = 7;
  localparam int MODE_W = 3;
  localparam int DIR_W = 2;
  localparam int PHREQ_W = 2;
  localparam int WIN_W = 4;

  typedef enum logic [MODE_W-1:0] {
    FCVS_OFF, FCVS_UF_GRAD, FCVS_OF_GRAD, FCVS_UF_CHG, FCVS_OF_CHG, FCVS_SURGE
  } fcvs_mode_t;
  typedef enum logic [DIR_W-1:0] {FCVS_DIR_POS, FCVS_DIR_NEG, FCVS_DIR_ABS} fcvs_dir_t;
  typedef enum logic [PHREQ_W-1:0] {FCVS_PH_ALL, FCVS_PH_TWO, FCVS_PH_ONE} fcvs_phreq_t;

  localparam logic [AW-1:0] REG_GRAD_WIN = 8'h00;
  localparam logic [AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AW-1:0] ELEM_BASE = 8'h40;
  localparam int ELEM_IDX_LSB = 5;
  localparam int REG_IDX_LSB = 2;
  localparam logic [2:0] ELEM_BASE_IDX = 3'h2;
  localparam logic [2:0] EREG_CFG = 3'h0;
  localparam logic [2:0] EREG_PICKUP = 3'h1;
  localparam logic [2:0] EREG_GRAD_THR = 3'h2;
  localparam logic [2:0] EREG_DELAY = 3'h3;
  localparam logic [2:0] EREG_CHG_LIMIT = 3'h4;
  localparam logic [2:0] EREG_INTERVAL = 3'h5;
  localparam logic [2:0] EREG_SURGE_THR = 3'h6;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_LSB = 4;
  localparam int CFG_PHREQ_LSB = 8;
  localparam int STAT_TRIP_LSB = 8;
  localparam logic [FW-1:0] EREG_RST = 16'h0000;

  localparam logic [WIN_W-1:0] GRAD_WIN_MIN = 4'h2;
  localparam logic [WIN_W-1:0] GRAD_WIN_MAX = 4'hA;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_HZ = 40_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC_DFLT = TICK_MS * MS_CYC;
  localparam int MAINS_FAIL_MS = 60;
  localparam int MAINS_FAIL_CYC_DFLT = MAINS_FAIL_MS * MS_CYC;
  localparam logic [47:0] ANGLE_FULL = 48'h0000_0000_0168;

  // Gradient test against a magnitude threshold; the sign bit marks a falling frequency.
  function automatic logic grad_exceeds(input logic [FW-1:0] g, input logic [FW-1:0] thr, input fcvs_dir_t dir);
    logic [FW-1:0] mag;
    logic big;
    mag = g[FW-1] ? FW'(~g + 1'b1) : g;
    big = mag > thr;
    case (dir)
      FCVS_DIR_POS: grad_exceeds = big && !g[FW-1];
      FCVS_DIR_NEG: grad_exceeds = big && g[FW-1];
      FCVS_DIR_ABS: grad_exceeds = big;
      default: grad_exceeds = 1'b0;
    endcase
  endfunction

  // Change since pickup: a decrease for the under variant, an increase for the over variant.
  function automatic logic freq_change_met(input logic [FW-1:0] fref, input logic [FW-1:0] f,
                                           input logic [FW-1:0] lim, input logic under);
    logic [FW:0] a;
    logic [FW:0] b;
    a = under ? {1'b0, fref} : {1'b0, f};
    b = under ? ({1'b0, f} + {1'b0, lim}) : ({1'b0, fref} + {1'b0, lim});
    freq_change_met = a >= b;
  endfunction

  // Division is avoided: dev/ref*360 > thr is tested as dev*360 > thr*ref.
  function automatic logic angle_exceeds(input logic [CW-1:0] dev, input logic [CW-1:0] refc,
                                         input logic [FW-1:0] thr);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(dev) * ANGLE_FULL;
    rhs = 48'(thr) * 48'(refc);
    angle_exceeds = lhs > rhs;
  endfunction

  function automatic logic [DW-1:0] apply_strb(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                                input logic [DW/8-1:0] strb);
    logic [DW-1:0] r;
    r = old;
    for (int b = 0; b < DW / 8; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    apply_strb = r;
  endfunction
endpackage

//--- test/fcvs_meas_model.sv
// Measurement stage model: per-phase frequency, gradient and zero crossings.
`timescale 1ns/10ps
module fcvs_meas_model
  import fcvs_pkg::*;
(
  input wire logic aclk,
  input wire logic [15:0] per,
  input wire logic [FW-1:0] f,
  input wire logic [FW-1:0] g,
  output logic [PHASES-1:0][FW-1:0] fph,
  output logic [PHASES-1:0][FW-1:0] gph,
  output logic [PHASES-1:0] zc
);
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] cnt_d;
  assign cnt_d = cnt_q + 16'h0001;
  always_ff @(posedge aclk) begin
    cnt_q <= (cnt_d >= per) ? 16'h0000 : cnt_d;
  end
  // A zero period is a dead mains, with no crossings at all, so the block must time out.
  assign zc = {PHASES{per != 16'h0000 && cnt_q == 16'h0000}};
  assign fph = {PHASES{f}};
  assign gph = {PHASES{g}};
endmodule

//--- test/test_frequency_combo_and_vector_surge_protect.sv
// Self-checking bench of the frequency protection block.
`timescale 1ns/10ps
module test_frequency_combo_and_vector_surge_protect;
  import fcvs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aw = 1'b0, wv = 1'b0, br = 1'b0, ar = 1'b0, rr = 1'b0, uv = 1'b0, pl = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [AW-1:0] aa = '0, ra = '0;
  logic [DW-1:0] wd = '0, rdata, rd;
  logic [1:0] rresp, rs, bresp, bs;
  logic [NELEM-1:0] blk = '0, alarm, trip;
  logic [11:0] st;
  logic [WIN_W-1:0] gwin;
  logic [15:0] per = 16'h0028;
  logic [FW-1:0] f = 16'h044C, g = 16'hFFEC;
  logic [PHASES-1:0][FW-1:0] fph, gph;
  logic [PHASES-1:0] zc;
  int err_total = 0, n_tests = 0, cyc = 0, m, hv;
  assign st = {trip, alarm};
  always #12.5 aclk = ~aclk;
  fcvs_meas_model fcvs_meas_model_inst (.aclk, .per, .f, .g, .fph, .gph, .zc);
  fcvs_top #(.TICK_CYC(4), .MAINS_FAIL_CYC(200)) fcvs_top_inst (.aclk, .aresetn, .s_axi_awaddr(aa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arprot(3'h0), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .freq_ph(fph), .grad_ph(gph), .zc_ph(zc),
    .uv_lock(uv), .phase_loss(pl), .elem_block(blk), .grad_window(gwin), .alarm, .trip);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aa <= a;
    wd <= d;
    aw <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) aw <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bs = bresp;
    br <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    ra <= a;
    ar <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) ar <= 1'b0;
    end while (rv !== 1'b1);
    rd = rdata;
    rs = rresp;
    rr <= 1'b0;
  endtask
  // Waits a bounded time for one alarm or trip bit, then compares it.
  task automatic wt(input int n, input int i, input logic v);
    m = 0;
    while (m < n && st[i] !== v) begin
      @(posedge aclk);
      m++;
    end
    chk("state", st[i], v);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'hF7E3_8800));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00);
    chk("win", rd, 32'h0000_0002);
    chk("rsp", rs, RESP_OKAY);
    wr(8'h00, 32'h0000_000F);
    chk("bresp", bs, RESP_OKAY);
    rdr(8'h00);
    chk("win", rd, 32'h0000_000A);
    chk("gwin", gwin, 32'h0000_000A);
    rdr(8'h5C);
    chk("rsp", rs, RESP_SLVERR);
    chk("rdz", rd, 32'h0000_0000);
    wr(8'h5C, 32'h0000_0001);
    chk("bresp", bs, RESP_SLVERR);
    wr(8'h44, 32'h0000_03E8);
    wr(8'h48, 32'h0000_000A);
    wr(8'h4C, 32'h0000_0005);
    for (int j = 0; j < 2; j++) begin
      for (int d = 0; d < 3; d++) begin
        f <= j ? 16'h044C : 16'h0384;
        wr(8'h40, 32'(j + 1 + d * 16));
        blk[0] <= 1'b0;
        wt(100, 0, d != 0);
        chk("early", trip[0], 1'b0);
        repeat (300) @(posedge aclk);
        chk("trip", trip[0], d != 0);
        rdr(8'h04);
        chk("stat", rd, (d != 0) ? 32'h0000_0101 : 32'h0000_0000);
        blk[0] <= 1'b1;
        wt(3, 0, 1'b0);
      end
    end
    wr(8'h50, 32'h0000_0032);
    wr(8'h54, 32'h0000_0064);
    for (int j = 0; j < 2; j++) begin
      hv = j ? 900 : 1100;
      f <= 16'(hv);
      wr(8'h40, 32'(j + 3));
      blk[0] <= 1'b0;
      f <= 16'(2000 - hv);
      wt(10, 0, 1'b1);
      f <= 16'(2000 - hv + (j ? 50 : -50));
      wt(10, 6, 1'b1);
      f <= 16'(hv);
      wt(10, 0, 1'b0);
      f <= 16'(2000 - hv);
      repeat (500) @(posedge aclk);
      f <= 16'(2000 - hv + (j ? 50 : -50));
      repeat (20) @(posedge aclk);
      chk("lock", trip[0], 1'b0);
      blk[0] <= 1'b1;
    end
    wr(8'h78, 32'h0000_000A);
    for (int k = 0; k < 5; k++) begin
      f <= 16'h0400 + 16'($urandom_range(100));
      pl <= k == 3;
      uv <= k == 4;
      wr(8'h60, 32'h0000_0005 + 32'(k % 3) * 32'h0000_0100);
      repeat (200) @(posedge aclk);
      chk("calm", trip[1], 1'b0);
      per <= 16'h001E;
      repeat ((k < 3) ? 0 : 60) @(posedge aclk);
      wt(60, 7, k < 3);
      chk("pair", alarm[1], k < 3);
      per <= 16'h0028;
    end
    pl <= 1'b0;
    uv <= 1'b0;
    wr(8'h60, 32'h0000_0205);
    repeat (200) @(posedge aclk);
    per <= 16'h0000;
    wt(210, 7, 1'b1);
    aresetn <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    chk("rst", st, 32'h0000_0000);
    close_out();
  end
endmodule
